// file: ipc_channel.sv
`default_nettype none

module ipc_channel
    import ipc_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // Supply monitors, high while the supply is above its lockout threshold
    input  wire logic primary_supply_ok_i,
    input  wire logic secondary_supply_ok_i,
    // Forward channel: primary input, secondary output
    input  wire logic data_in_i,
    output logic      tx_set_pulse_o,
    output logic      tx_reset_pulse_o,
    output logic      tx_ready_o,
    input  wire logic barrier_stall_i,
    output logic      data_out_o,
    output logic      data_out_oe_o,
    // Reverse channel output on the primary side
    input  wire logic rev_set_i,
    input  wire logic rev_reset_i,
    output logic      rev_out_o,
    output logic      rev_out_oe_o,
    // Power converter
    output logic      osc_enable_o
);

    // ==========================================================================
    // Declarations
    // ==========================================================================
    logic          in_prev_r;
    logic          pending_r;
    logic          pend_level_r;
    logic [7:0]    idle_cnt_r;
    logic          edge_seen;
    logic          refresh_due;
    logic          push;
    logic          fifo_ready;
    logic          rx_valid;
    logic          rx_ready;
    logic [0:0]    rx_sym;
    logic          rx_take;
    logic [7:0]    wdog_cnt_r;
    logic          wdog_trip;
    logic          sec_ok_prev_r;
    ipc_ch_state_t rx_state_r;
    ipc_ch_state_t rx_state_nxt;
    logic          rx_level_r;
    ipc_ch_state_t rev_state_r;
    logic          rev_level_r;

    // ==========================================================================
    // Transmit side: edge detection and refresh
    // ==========================================================================
    // While the primary supply is low the input is not sampled; a level that
    // differs from the last one sampled goes out as an edge once it returns.
    assign edge_seen   = primary_supply_ok_i && (data_in_i != in_prev_r);
    assign refresh_due = primary_supply_ok_i && (idle_cnt_r >= REFRESH_CYC);
    assign push        = primary_supply_ok_i && pending_r && fifo_ready;
    assign tx_ready_o  = fifo_ready;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_prev_r <= INIT_LEVEL;
        end else if (primary_supply_ok_i) begin
            in_prev_r <= data_in_i;
        end
    end

    // A newer edge replaces a symbol still waiting on a full buffer, since only
    // the latest level matters to the bistable decoder.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_r    <= 1'b0;
            pend_level_r <= INIT_LEVEL;
        end else if (!primary_supply_ok_i) begin
            pending_r    <= 1'b0;
        end else if (edge_seen) begin
            pending_r    <= 1'b1;
            pend_level_r <= data_in_i;
        end else if (refresh_due && !pending_r) begin
            pending_r    <= 1'b1;
            pend_level_r <= in_prev_r;
        end else if (push) begin
            pending_r    <= 1'b0;
        end
    end

    // The refresh period is the idle threshold plus two cycles, far below the watchdog.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_cnt_r <= CNT_RESET;
        end else if (!primary_supply_ok_i || push || edge_seen) begin
            idle_cnt_r <= CNT_RESET;
        end else if (idle_cnt_r < REFRESH_CYC) begin
            idle_cnt_r <= idle_cnt_r + 8'h01;
        end
    end

    // ==========================================================================
    // Transmit side: pulse driver
    // ==========================================================================
    // Each pushed symbol leaves as a single-cycle pulse, the shortest this
    // clock can make, so two symbols never merge on the barrier.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_set_pulse_o   <= 1'b0;
            tx_reset_pulse_o <= 1'b0;
        end else begin
            tx_set_pulse_o   <= primary_supply_ok_i && push && pend_level_r;
            tx_reset_pulse_o <= primary_supply_ok_i && push && !pend_level_r;
        end
    end

    // ==========================================================================
    // Barrier buffer
    // ==========================================================================
    // Pulses reaching an unpowered secondary are simply lost, as in silicon.
    assign rx_ready = !barrier_stall_i;
    assign rx_take  = rx_valid && rx_ready && secondary_supply_ok_i;

    ipc_fifo #(
        .WIDTH (SYM_W),
        .DEPTH (FIFO_DEPTH)
    ) u_barrier_fifo (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (pend_level_r),
        .out_valid_o (rx_valid),
        .out_ready_i (rx_ready),
        .out_data_o  (rx_sym)
    );

    // ==========================================================================
    // Receive side: watchdog
    // ==========================================================================
    assign wdog_trip = (wdog_cnt_r >= WDOG_CYC);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wdog_cnt_r <= CNT_RESET;
        end else if (!secondary_supply_ok_i || rx_take) begin
            wdog_cnt_r <= CNT_RESET;
        end else if (!wdog_trip) begin
            wdog_cnt_r <= wdog_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_ok_prev_r <= 1'b0;
        end else begin
            sec_ok_prev_r <= secondary_supply_ok_i;
        end
    end

    // ==========================================================================
    // Receive side: decoder state
    // ==========================================================================
    always_comb begin
        rx_state_nxt = rx_state_r;
        case (rx_state_r)
            CH_OFF: begin
                if (secondary_supply_ok_i && !sec_ok_prev_r) begin
                    rx_state_nxt = CH_INIT;
                end
            end
            // A symbol taken in the tripping cycle wins over the watchdog.
            CH_INIT, CH_LIVE, CH_LOST: begin
                if (rx_take) begin
                    rx_state_nxt = CH_LIVE;
                end else if (wdog_trip) begin
                    rx_state_nxt = CH_LOST;
                end
            end
            default: begin
                rx_state_nxt = CH_OFF;
            end
        endcase
        if (!secondary_supply_ok_i) begin
            rx_state_nxt = CH_OFF;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state_r <= CH_OFF;
        end else begin
            rx_state_r <= rx_state_nxt;
        end
    end

    // Bistable element: kept through primary loss until the watchdog trips.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_level_r <= INIT_LEVEL;
        end else if (rx_take) begin
            rx_level_r <= rx_sym[0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_out_o    <= INIT_LEVEL;
            data_out_oe_o <= 1'b0;
        end else begin
            data_out_oe_o <= (rx_state_nxt != CH_OFF);
            case (rx_state_nxt)
                CH_INIT: data_out_o <= INIT_LEVEL;
                CH_LIVE: data_out_o <= rx_take ? rx_sym[0] : rx_level_r;
                CH_LOST: data_out_o <= WDOG_LEVEL;
                default: data_out_o <= INIT_LEVEL;
            endcase
        end
    end

    // ==========================================================================
    // Primary side: reverse output and power oscillator
    // ==========================================================================
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rev_state_r <= CH_OFF;
            rev_level_r <= INIT_LEVEL;
        end else if (!primary_supply_ok_i) begin
            rev_state_r <= CH_OFF;
            rev_level_r <= INIT_LEVEL;
        end else if (rev_set_i || rev_reset_i) begin
            rev_state_r <= CH_LIVE;
            rev_level_r <= rev_set_i;
        end else if (rev_state_r == CH_OFF) begin
            rev_state_r <= CH_INIT;
            rev_level_r <= INIT_LEVEL;
        end
    end

    // Set wins when both reverse pulses arrive together.
    assign rev_out_o    = rev_level_r;
    assign rev_out_oe_o = (rev_state_r != CH_OFF);
    assign osc_enable_o = primary_supply_ok_i;

endmodule : ipc_channel

`default_nettype wire

// file: ipc_pkg.sv
`default_nettype none

package ipc_pkg;

    // ==========================================================================
    // Clock and timing
    // ==========================================================================
    localparam int unsigned CLK_PERIOD_NS = 25;

    // Edge pulses are about 1 ns wide; at this clock rate that is one cycle.
    localparam int unsigned PULSE_NS      = 1;
    localparam int unsigned PULSE_CYC_I   = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  PULSE_CYC     = 2'((PULSE_CYC_I < 1) ? 1 : PULSE_CYC_I);

    // Idle time after which refresh pulses start, rounded up.
    localparam int unsigned REFRESH_NS    = 1000;
    localparam logic [7:0]  REFRESH_CYC   = 8'((REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Decoder silence that trips the watchdog, rounded down.
    localparam int unsigned WDOG_NS       = 5000;
    localparam logic [7:0]  WDOG_CYC      = 8'(WDOG_NS / CLK_PERIOD_NS);

    // ==========================================================================
    // Levels and reset values
    // ==========================================================================
    localparam logic        INIT_LEVEL    = 1'b0;
    localparam logic        WDOG_LEVEL    = 1'b1;
    localparam logic [7:0]  CNT_RESET     = 8'h00;

    // ==========================================================================
    // Barrier symbol buffer
    // ==========================================================================
    localparam int unsigned SYM_W         = 1;
    localparam int unsigned FIFO_DEPTH    = 8;

    // ==========================================================================
    // Output channel states
    // ==========================================================================
    typedef enum logic [1:0] {
        CH_OFF  = 2'b00,
        CH_INIT = 2'b01,
        CH_LIVE = 2'b11,
        CH_LOST = 2'b10
    } ipc_ch_state_t;

endpackage : ipc_pkg

`default_nettype wire

// file: ipc_fifo.sv
`default_nettype none

module ipc_fifo
    import ipc_pkg::*;
#(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    // ==========================================================================
    // Storage and pointers
    // ==========================================================================
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;
    logic             empty;
    logic             full;
    logic             push;
    logic             load;
    logic             out_valid_r;
    logic [WIDTH-1:0] out_data_r;

    assign empty       = (wr_ptr_r == rd_ptr_r);
    assign full        = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign in_ready_o  = !full;
    assign push        = in_valid_i && !full;
    // The head word moves into the output register whenever that stage is free.
    assign load        = !empty && (!out_valid_r || out_ready_i);
    assign out_valid_o = out_valid_r;
    assign out_data_o  = out_data_r;

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= '0;
        end else if (push) begin
            wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_ptr_r <= '0;
        end else if (load) begin
            rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
        end
    end

    // ==========================================================================
    // Registered read port
    // ==========================================================================
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
        end else if (load) begin
            out_valid_r <= 1'b1;
            out_data_r  <= mem_r[rd_ptr_r[AW-1:0]];
        end else if (out_ready_i) begin
            out_valid_r <= 1'b0;
        end
    end

endmodule : ipc_fifo

`default_nettype wire

// file: ipc_channel_checker.sv
`default_nettype none

module ipc_channel_checker
    import ipc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Supply monitors
    input wire logic primary_supply_ok_i,
    input wire logic secondary_supply_ok_i,
    // Forward channel
    input wire logic tx_set_pulse_o,
    input wire logic tx_reset_pulse_o,
    input wire logic tx_ready_o,
    input wire logic barrier_stall_i,
    input wire logic data_out_o,
    input wire logic data_out_oe_o,
    // Reverse channel and converter
    input wire logic rev_set_i,
    input wire logic rev_reset_i,
    input wire logic rev_out_o,
    input wire logic rev_out_oe_o,
    input wire logic osc_enable_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ==========================================================================
    // Silence counters
    // ==========================================================================
    // A stall or a pulse restarts the low-output count, since either may postpone the take.
    logic [8:0] wd_cnt_r;
    logic [8:0] rf_cnt_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wd_cnt_r <= 9'h000;
        end else if (!data_out_oe_o || data_out_o || barrier_stall_i || tx_set_pulse_o
                     || tx_reset_pulse_o) begin
            wd_cnt_r <= 9'h000;
        end else if (wd_cnt_r != 9'h1ff) begin
            wd_cnt_r <= wd_cnt_r + 9'h001;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rf_cnt_r <= 9'h000;
        end else if (!primary_supply_ok_i || !tx_ready_o || tx_set_pulse_o
                     || tx_reset_pulse_o) begin
            rf_cnt_r <= 9'h000;
        end else if (rf_cnt_r != 9'h1ff) begin
            rf_cnt_r <= rf_cnt_r + 9'h001;
        end
    end

    // ==========================================================================
    // Properties
    // ==========================================================================
    osc_follow_a: assert property (osc_enable_o == primary_supply_ok_i)
        else $error("oscillator enable differs from primary supply");
    lock_quiet_a: assert property ((!primary_supply_ok_i) [*3] |->
        !tx_set_pulse_o && !tx_reset_pulse_o) else $error("pulse during lockout");
    pulse_type_a: assert property (!(tx_set_pulse_o && tx_reset_pulse_o))
        else $error("set and reset pulse together");
    pulse_short_a: assert property ((tx_set_pulse_o |=> !tx_set_pulse_o) and
        (tx_reset_pulse_o |=> !tx_reset_pulse_o)) else $error("pulse longer than one cycle");
    sec_hiz_a: assert property (!secondary_supply_ok_i |=> !data_out_oe_o)
        else $error("secondary output driven in lockout");
    pri_hiz_a: assert property (!primary_supply_ok_i |=> !rev_out_oe_o)
        else $error("primary output driven in lockout");
    sec_init_a: assert property ($rose(secondary_supply_ok_i) |=>
        data_out_oe_o && !data_out_o) else $error("secondary output not initialised low");
    pri_init_a: assert property ($rose(primary_supply_ok_i) && !rev_set_i |=>
        rev_out_oe_o && !rev_out_o) else $error("primary output not initialised low");
    rev_follow_a: assert property (primary_supply_ok_i && rev_out_oe_o &&
        (rev_set_i || rev_reset_i) |=> rev_out_o == $past(rev_set_i))
        else $error("reverse output does not follow pulse");
    wdog_bound_a: assert property (wd_cnt_r <= 9'(WDOG_CYC) + 9'h010)
        else $error("output low too long without pulses");
    refresh_bound_a: assert property (rf_cnt_r <= 9'(REFRESH_CYC) + 9'h008)
        else $error("no refresh pulse while idle");
endmodule : ipc_channel_checker

bind ipc_channel ipc_channel_checker chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .primary_supply_ok_i(primary_supply_ok_i), .secondary_supply_ok_i(secondary_supply_ok_i),
    .tx_set_pulse_o(tx_set_pulse_o), .tx_reset_pulse_o(tx_reset_pulse_o),
    .tx_ready_o(tx_ready_o), .barrier_stall_i(barrier_stall_i), .data_out_o(data_out_o),
    .data_out_oe_o(data_out_oe_o), .rev_set_i(rev_set_i), .rev_reset_i(rev_reset_i),
    .rev_out_o(rev_out_o), .rev_out_oe_o(rev_out_oe_o), .osc_enable_o(osc_enable_o));

`default_nettype wire

// file: ipc_far_model.sv
`default_nettype none

module ipc_far_model
    import ipc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // Forward pulses seen at the barrier
    input  wire logic        tx_set_pulse_i,
    input  wire logic        tx_reset_pulse_i,
    output logic             seen_level_o,
    output logic      [15:0] pulse_cnt_o,
    // Reverse input level sent back as edge pulses
    input  wire logic        rev_level_i,
    output logic             rev_set_o,
    output logic             rev_reset_o
);
    logic rev_last_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_level_o <= INIT_LEVEL;
            pulse_cnt_o  <= 16'h0000;
        end else if (tx_set_pulse_i || tx_reset_pulse_i) begin
            seen_level_o <= tx_set_pulse_i;
            pulse_cnt_o  <= pulse_cnt_o + 16'h0001;
        end
    end

    // Only edges travel back; no refresh is sent, so the far output must hold by itself.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rev_last_r  <= 1'b0;
            rev_set_o   <= 1'b0;
            rev_reset_o <= 1'b0;
        end else begin
            rev_last_r  <= rev_level_i;
            rev_set_o   <= rev_level_i && !rev_last_r;
            rev_reset_o <= !rev_level_i && rev_last_r;
        end
    end
endmodule : ipc_far_model

`default_nettype wire

// file: ipc_channel_bench.sv
`default_nettype none

module ipc_channel_bench
    import ipc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        core_clk_i, rst_n_i, pri_ok, sec_ok, din, stall, rev_lvl;
    logic        tx_set, tx_reset, tx_ready, dout, dout_oe, osc;
    logic        rev_set, rev_reset, rev_out, rev_oe, seen_lvl;
    logic [15:0] pcnt;
    int          n_errors, compares, cyc, base, seen_full, bad_run, lvl_m;

    ipc_channel uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .primary_supply_ok_i(pri_ok),
        .secondary_supply_ok_i(sec_ok), .data_in_i(din), .tx_set_pulse_o(tx_set),
        .tx_reset_pulse_o(tx_reset), .tx_ready_o(tx_ready), .barrier_stall_i(stall),
        .data_out_o(dout), .data_out_oe_o(dout_oe), .rev_set_i(rev_set), .rev_reset_i(rev_reset),
        .rev_out_o(rev_out), .rev_out_oe_o(rev_oe), .osc_enable_o(osc));

    ipc_far_model far (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .tx_set_pulse_i(tx_set),
        .tx_reset_pulse_i(tx_reset), .seen_level_o(seen_lvl), .pulse_cnt_o(pcnt),
        .rev_level_i(rev_lvl), .rev_set_o(rev_set), .rev_reset_o(rev_reset));

    // ==========================================================================
    // Clock, timeout and helpers
    // ==========================================================================
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            conclude();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #2;
    endtask : tick

    task automatic chk_bit(input logic got, input logic exp);
        compares = compares + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_cnt(input int got, input int exp);
        compares = compares + 1;
        if (got != exp) begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt

    // Rule model: every pulse, edge or refresh, carries the input level last
    // sampled while the primary supply was good. Sampled mid-cycle when settled.
    always @(negedge core_clk_i) begin
        if (rst_n_i === 1'b1 && (tx_set === 1'b1 || tx_reset === 1'b1)) begin
            chk_bit(tx_set, (lvl_m != 0));
        end
        if (pri_ok === 1'b1) begin
            lvl_m = int'(din);
        end
    end

    // One edge in, one typed pulse out, then the far output follows.
    task automatic send(input logic lvl);
        int k;
        din = lvl;
        tick(1);
        for (k = 0; k < 10 && tx_set !== 1'b1 && tx_reset !== 1'b1; k++) tick(1);
        chk_bit(tx_set, lvl);
        chk_bit(tx_reset, !lvl);
        for (k = 0; k < 10 && dout !== lvl; k++) tick(1);
        chk_bit(dout, lvl);
    endtask : send

    task automatic conclude();
        $display("counts compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // ==========================================================================
    // Main sequence
    // ==========================================================================
    initial begin
        cyc = 0;
        n_errors = 0;
        compares = 0;
        lvl_m = int'(INIT_LEVEL);
        {rst_n_i, pri_ok, sec_ok, din, stall, rev_lvl} = 6'h00;
        base = $urandom(32'h7660);
        tick(16);
        rst_n_i = 1'b1;
        tick(2);
        chk_bit(dout_oe, 1'b0);
        chk_bit(rev_oe, 1'b0);
        chk_bit(osc, 1'b0);
        chk_bit(tx_ready, 1'b1);
        $display("test reset done");

        base = int'(pcnt);
        repeat (20) begin
            din = 1'($urandom);
            tick(3);
        end
        din = 1'b0;
        tick(4);
        chk_cnt(int'(pcnt) - base, 0);
        $display("test lockout done");

        sec_ok = 1'b1;
        tick(2);
        chk_bit(dout_oe, 1'b1);
        chk_bit(dout, INIT_LEVEL);
        tick(int'(WDOG_CYC) + 10);
        chk_bit(dout, WDOG_LEVEL);
        $display("test secondary start done");

        pri_ok = 1'b1;
        tick(2);
        chk_bit(osc, 1'b1);
        chk_bit(rev_oe, 1'b1);
        chk_bit(rev_out, 1'b0);
        for (int i = 0; i < 16; i++) begin
            rev_lvl = 1'($urandom);
            send(!din);
            tick(2 + int'($urandom % 8));
            chk_bit(rev_out, rev_lvl);
        end
        $display("test edges done");

        base = int'(pcnt);
        bad_run = 0;
        repeat (300) begin
            tick(1);
            if (dout !== din) bad_run++;
        end
        chk_cnt(bad_run, 0);
        chk_bit(((int'(pcnt) - base) inside {[6:8]}), 1'b1);
        chk_bit(seen_lvl, din);
        for (int k = 0; k < 60 && tx_reset !== 1'b1; k++) tick(1);
        $display("test refresh done");

        stall = 1'b1;
        base = int'(pcnt);
        seen_full = 0;
        repeat (11) begin
            din = !din;
            tick(3);
            if (tx_ready === 1'b0) seen_full = 1;
        end
        tick(4);
        chk_cnt(seen_full, 1);
        chk_cnt(int'(pcnt) - base, int'(FIFO_DEPTH) + 1);
        chk_bit(dout, 1'b0);
        stall = 1'b0;
        tick(30);
        chk_cnt(int'(pcnt) - base, int'(FIFO_DEPTH) + 2);
        chk_bit(dout, din);
        send(1'b0);
        $display("test buffer done");

        pri_ok = 1'b0;
        tick(20);
        chk_bit(dout, 1'b0);
        chk_bit(rev_oe, 1'b0);
        chk_bit(osc, 1'b0);
        tick(int'(WDOG_CYC) + 10);
        chk_bit(dout, WDOG_LEVEL);
        sec_ok = 1'b0;
        tick(2);
        chk_bit(dout_oe, 1'b0);
        $display("test power loss done");
        conclude();
    end
endmodule : ipc_channel_bench

`default_nettype wire
